// ---- shared/ext_reg_pkg.sv ----
/*
  Constants, codes and types of the extension register command engine.
  Assumes one 50 MHz clock domain; shared by the rtl and the bench.
*/
package ext_reg_pkg;
  // ==========================================================
  // Widths
  localparam int WORD_W = 16;
  localparam int BLK_W = 9;
  localparam int OFS_W = 13;
  localparam int DEV_W = 18;
  localparam int PTS_W = 7;
  localparam int ADDR_W = 22;
  localparam int CHR_W = 8;
  localparam int CODE_W = 8;

  // ==========================================================
  // Block geometry: each numbered block holds 8192 words
  localparam logic [OFS_W-1:0] OFS_LAST = 13'h1fff;
  localparam logic [PTS_W-1:0] PTS_MAX = 7'h40;
  localparam logic [BLK_W-1:0] BLK_PARAM = 9'h000;
  localparam logic [BLK_W-1:0] BLK_FIRST = 9'h001;
  localparam logic [BLK_W-1:0] SMALL_LAST_BLK = 9'h003;
  localparam logic [BLK_W-1:0] LARGE_GAP_BLK = 9'h009;
  localparam logic [BLK_W-1:0] LARGE_LAST_BLK = 9'h010;
  localparam logic [BLK_W-1:0] LARGE_USABLE = 9'h00f;

  // ==========================================================
  // Command characters
  localparam logic [CHR_W-1:0] CHR_E = 8'h45;
  localparam logic [CHR_W-1:0] CHR_N = 8'h4e;
  localparam logic [CHR_W-1:0] CHR_R = 8'h52;
  // Named apart from the width constant CHR_W, which it would shadow
  localparam logic [CHR_W-1:0] CHR_WRITE = 8'h57;

  // ==========================================================
  // Error codes
  localparam logic [CODE_W-1:0] ERR_NONE = 8'h00;
  localparam logic [CODE_W-1:0] ERR_BLOCK = 8'h06;
  localparam logic [CODE_W-1:0] ERR_RANGE = 8'h10;
  localparam logic [CODE_W-1:0] ERR_CMD = 8'h11;
  localparam logic [CODE_W-1:0] ERR_NOEXT = 8'h12;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    CPU_NO_EXT, CPU_SMALL, CPU_LARGE, CPU_GENERAL
  } cpu_kind_t;

  typedef enum logic [1:0] {
    OP_BREAD, OP_BWRITE, OP_DREAD, OP_BAD
  } op_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_CHECK, ST_FETCH, ST_MEM, ST_PUSH, ST_DONE
  } state_t;
endpackage

// ---- shared/word_if.sv ----
/*
  Valid/ready word stream between the command engine and its buffer.
  Assumes both ends share one clock.
*/
interface word_if #(parameter int W = 16);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ---- rtl/two_entry_buffer.sv ----
/*
  Two-entry buffer in the reply data path.
  Assumes a synchronous source on the stream side and a plain sink.
*/
module two_entry_buffer #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Filling side
  word_if.snk in_s,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] slot0_r;
  logic [W-1:0] slot1_r;
  logic [1:0] cnt_r;
  logic push;
  logic pop;

  // ==========================================================
  // Handshakes
  assign in_s.ready = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data = slot0_r;
  assign push = in_s.valid && in_s.ready;
  assign pop = out_valid && out_ready;

  // ==========================================================
  // Occupancy
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_r <= 2'h0;
    end else if (push && !pop) begin
      cnt_r <= cnt_r + 2'h1;
    end else if (pop && !push) begin
      cnt_r <= cnt_r - 2'h1;
    end
  end

  // ==========================================================
  // Storage: head always sits in slot0 so the output is a flop
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      slot0_r <= '0;
      slot1_r <= '0;
    end else begin
      if (pop) begin
        slot0_r <= (cnt_r == 2'h2) ? slot1_r : in_s.data;
        if (push && cnt_r == 2'h2) begin
          slot1_r <= in_s.data;
        end
      end else if (push) begin
        if (cnt_r == 2'h0) begin
          slot0_r <= in_s.data;
        end else begin
          slot1_r <= in_s.data;
        end
      end
    end
  end
endmodule // two_entry_buffer

// ---- rtl/ext_reg_cmd.sv ----
/*
  Command engine for extension register batch read, batch write and
  direct read. Assumes the frame has been parsed into one request
  word set, and that the CPU memory port answers each request with
  a one-cycle ack.
*/
// What this block does
// - Flat device number maps to 8192-word blocks
// - No access on CPUs without extension registers
// - Missing block answers 06H when detectable
// - Command content is that of format 1
// - Valid block set follows CPU variant
// - Batch read returns consecutive words
// - Three two-character ASCII command codes
module ext_reg_cmd (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Installed CPU and memory
  input wire ext_reg_pkg::cpu_kind_t cpu_kind,
  input wire logic [ext_reg_pkg::BLK_W-1:0] block_limit,
  input wire logic block_detect,
  // Parsed request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [ext_reg_pkg::CHR_W-1:0] req_cmd0,
  input wire logic [ext_reg_pkg::CHR_W-1:0] req_cmd1,
  input wire logic [ext_reg_pkg::BLK_W-1:0] req_block,
  input wire logic [ext_reg_pkg::OFS_W-1:0] req_word,
  input wire logic [ext_reg_pkg::DEV_W-1:0] req_dev,
  input wire logic [ext_reg_pkg::PTS_W-1:0] req_points,
  // Write words from the host
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [ext_reg_pkg::WORD_W-1:0] wr_data,
  // Read words to the host
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [ext_reg_pkg::WORD_W-1:0] rd_data,
  // Completion
  output logic done,
  output logic err,
  output logic [ext_reg_pkg::CODE_W-1:0] err_code,
  // CPU memory port
  output logic mem_req,
  output logic mem_we,
  output logic [ext_reg_pkg::BLK_W-1:0] mem_block,
  output logic [ext_reg_pkg::OFS_W-1:0] mem_word,
  output logic [ext_reg_pkg::WORD_W-1:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [ext_reg_pkg::WORD_W-1:0] mem_rdata
);
  localparam int AW = ext_reg_pkg::ADDR_W;
  localparam int BW = ext_reg_pkg::BLK_W;
  localparam int OW = ext_reg_pkg::OFS_W;

  ext_reg_pkg::state_t state_r;
  ext_reg_pkg::op_t op_r;
  logic [ext_reg_pkg::CHR_W-1:0] cmd0_r;
  logic [ext_reg_pkg::CHR_W-1:0] cmd1_r;
  logic [BW-1:0] blk_r;
  logic [OW-1:0] word_r;
  logic [ext_reg_pkg::DEV_W-1:0] dev_r;
  logic [ext_reg_pkg::PTS_W-1:0] pts_r;
  logic [BW-1:0] cur_blk_r;
  logic [OW-1:0] cur_word_r;
  logic [ext_reg_pkg::PTS_W-1:0] left_r;
  logic [ext_reg_pkg::WORD_W-1:0] data_r;
  logic err_r;
  logic [ext_reg_pkg::CODE_W-1:0] code_r;
  ext_reg_pkg::op_t op_dec;
  logic [BW-1:0] dmap_blk;
  logic [OW-1:0] dev_ofs;
  logic [AW-1:0] req_end;
  logic [AW-1:0] dev_span;
  logic blk_missing;
  logic chk_err;
  logic [ext_reg_pkg::CODE_W-1:0] chk_code;
  logic last_word;

  word_if #(.W(ext_reg_pkg::WORD_W)) push_s ();

  // ==========================================================
  // Block set of each CPU variant
  function automatic logic blk_exists(ext_reg_pkg::cpu_kind_t k,
                                      logic [BW-1:0] lim,
                                      logic [BW-1:0] b);
    logic ok;
    ok = 1'b0;
    case (k)
      ext_reg_pkg::CPU_SMALL: ok = (b <= ext_reg_pkg::SMALL_LAST_BLK);
      ext_reg_pkg::CPU_LARGE: ok = (b <= ext_reg_pkg::LARGE_LAST_BLK) &&
                                   (b != ext_reg_pkg::LARGE_GAP_BLK);
      ext_reg_pkg::CPU_GENERAL: ok = (b <= lim);
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // Next existing block; direct numbering skips the missing one
  function automatic logic [BW-1:0] next_blk(ext_reg_pkg::cpu_kind_t k,
                                             logic [BW-1:0] b);
    logic [BW-1:0] n;
    n = b + ext_reg_pkg::BLK_FIRST;
    if (k == ext_reg_pkg::CPU_LARGE && n == ext_reg_pkg::LARGE_GAP_BLK) begin
      n = n + ext_reg_pkg::BLK_FIRST;
    end
    return n;
  endfunction

  function automatic logic [BW-1:0] usable(ext_reg_pkg::cpu_kind_t k,
                                           logic [BW-1:0] lim);
    logic [BW-1:0] u;
    u = '0;
    case (k)
      ext_reg_pkg::CPU_SMALL: u = ext_reg_pkg::SMALL_LAST_BLK;
      ext_reg_pkg::CPU_LARGE: u = ext_reg_pkg::LARGE_USABLE;
      ext_reg_pkg::CPU_GENERAL: u = lim;
      default: u = '0;
    endcase
    return u;
  endfunction

  // ==========================================================
  // Decode and checks
  always_comb begin
    op_dec = ext_reg_pkg::OP_BAD;
    if (cmd0_r == ext_reg_pkg::CHR_E && cmd1_r == ext_reg_pkg::CHR_R) begin
      op_dec = ext_reg_pkg::OP_BREAD;
    end else if (cmd0_r == ext_reg_pkg::CHR_E &&
                 cmd1_r == ext_reg_pkg::CHR_WRITE) begin
      op_dec = ext_reg_pkg::OP_BWRITE;
    end else if (cmd0_r == ext_reg_pkg::CHR_N &&
                 cmd1_r == ext_reg_pkg::CHR_R) begin
      op_dec = ext_reg_pkg::OP_DREAD;
    end
  end

  // Block index counts only existing blocks, first one at zero
  assign dev_ofs = dev_r[OW-1:0];
  assign dmap_blk = (cpu_kind == ext_reg_pkg::CPU_LARGE &&
      BW'(dev_r[ext_reg_pkg::DEV_W-1:OW]) >= ext_reg_pkg::LARGE_GAP_BLK -
      ext_reg_pkg::BLK_FIRST) ?
      BW'(dev_r[ext_reg_pkg::DEV_W-1:OW]) + ext_reg_pkg::BLK_FIRST +
      ext_reg_pkg::BLK_FIRST :
      BW'(dev_r[ext_reg_pkg::DEV_W-1:OW]) + ext_reg_pkg::BLK_FIRST;
  assign dev_span = AW'(usable(cpu_kind, block_limit)) << OW;
  assign req_end = (op_dec == ext_reg_pkg::OP_DREAD) ?
      AW'(dev_r) + AW'(pts_r) : AW'(word_r) + AW'(pts_r);
  assign blk_missing = !blk_exists(cpu_kind, block_limit, blk_r);

  always_comb begin
    chk_err = 1'b1;
    chk_code = ext_reg_pkg::ERR_NONE;
    if (op_dec == ext_reg_pkg::OP_BAD) begin
      chk_code = ext_reg_pkg::ERR_CMD;
    end else if (cpu_kind == ext_reg_pkg::CPU_NO_EXT) begin
      chk_code = ext_reg_pkg::ERR_NOEXT;
    end else if (pts_r == '0 || pts_r > ext_reg_pkg::PTS_MAX) begin
      chk_code = ext_reg_pkg::ERR_RANGE;
    end else if (op_dec == ext_reg_pkg::OP_DREAD) begin
      chk_err = (req_end > dev_span);
      chk_code = chk_err ? ext_reg_pkg::ERR_RANGE : ext_reg_pkg::ERR_NONE;
    end else if (req_end > AW'(ext_reg_pkg::OFS_LAST) + AW'(1)) begin
      chk_code = ext_reg_pkg::ERR_RANGE;
    end else if (blk_missing && block_detect) begin
      chk_code = ext_reg_pkg::ERR_BLOCK;
    end else begin
      chk_err = 1'b0;
    end
  end

  assign last_word = (left_r == ext_reg_pkg::PTS_W'(1));

  // ==========================================================
  // Request capture
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cmd0_r <= '0;
      cmd1_r <= '0;
      blk_r <= '0;
      word_r <= '0;
      dev_r <= '0;
      pts_r <= '0;
    end else if (req_valid && req_ready) begin
      cmd0_r <= req_cmd0;
      cmd1_r <= req_cmd1;
      blk_r <= req_block;
      word_r <= req_word;
      dev_r <= req_dev;
      pts_r <= req_points;
    end
  end

  // ==========================================================
  // Sequencer
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r <= ext_reg_pkg::ST_IDLE;
    end else begin
      case (state_r)
        ext_reg_pkg::ST_IDLE: begin
          if (req_valid) begin
            state_r <= ext_reg_pkg::ST_CHECK;
          end
        end
        ext_reg_pkg::ST_CHECK: begin
          if (chk_err) begin
            state_r <= ext_reg_pkg::ST_DONE;
          end else if (op_dec == ext_reg_pkg::OP_BWRITE) begin
            state_r <= ext_reg_pkg::ST_FETCH;
          end else begin
            state_r <= ext_reg_pkg::ST_MEM;
          end
        end
        ext_reg_pkg::ST_FETCH: begin
          if (wr_valid) begin
            state_r <= ext_reg_pkg::ST_MEM;
          end
        end
        ext_reg_pkg::ST_MEM: begin
          if (mem_ack) begin
            if (op_r != ext_reg_pkg::OP_BWRITE) begin
              state_r <= ext_reg_pkg::ST_PUSH;
            end else if (last_word) begin
              state_r <= ext_reg_pkg::ST_DONE;
            end else begin
              state_r <= ext_reg_pkg::ST_FETCH;
            end
          end
        end
        ext_reg_pkg::ST_PUSH: begin
          if (push_s.ready) begin
            state_r <= last_word ? ext_reg_pkg::ST_DONE :
                                   ext_reg_pkg::ST_MEM;
          end
        end
        default: state_r <= ext_reg_pkg::ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Address walk
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      op_r <= ext_reg_pkg::OP_BAD;
      cur_blk_r <= '0;
      cur_word_r <= '0;
      left_r <= '0;
    end else if (state_r == ext_reg_pkg::ST_CHECK) begin
      op_r <= op_dec;
      left_r <= pts_r;
      if (op_dec == ext_reg_pkg::OP_DREAD) begin
        cur_blk_r <= dmap_blk;
        cur_word_r <= dev_ofs;
      end else begin
        cur_blk_r <= blk_r;
        cur_word_r <= word_r;
      end
    end else if ((state_r == ext_reg_pkg::ST_MEM && mem_ack &&
                  op_r == ext_reg_pkg::OP_BWRITE) ||
                 (state_r == ext_reg_pkg::ST_PUSH && push_s.ready)) begin
      left_r <= left_r - ext_reg_pkg::PTS_W'(1);
      if (cur_word_r == ext_reg_pkg::OFS_LAST) begin
        cur_word_r <= '0;
        cur_blk_r <= next_blk(cpu_kind, cur_blk_r);
      end else begin
        cur_word_r <= cur_word_r + OW'(1);
      end
    end
  end

  // Write word is staged so the memory sees flop-driven data
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      data_r <= '0;
    end else if (state_r == ext_reg_pkg::ST_FETCH && wr_valid) begin
      data_r <= wr_data;
    end else if (state_r == ext_reg_pkg::ST_MEM && mem_ack &&
                 op_r != ext_reg_pkg::OP_BWRITE) begin
      data_r <= mem_rdata;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      err_r <= 1'b0;
      code_r <= ext_reg_pkg::ERR_NONE;
    end else if (state_r == ext_reg_pkg::ST_CHECK) begin
      err_r <= chk_err;
      code_r <= chk_code;
    end
  end

  // ==========================================================
  // Outputs
  assign req_ready = (state_r == ext_reg_pkg::ST_IDLE);
  assign wr_ready = (state_r == ext_reg_pkg::ST_FETCH);
  assign mem_req = (state_r == ext_reg_pkg::ST_MEM);
  assign mem_we = (op_r == ext_reg_pkg::OP_BWRITE);
  assign mem_block = cur_blk_r;
  assign mem_word = cur_word_r;
  assign mem_wdata = data_r;
  assign done = (state_r == ext_reg_pkg::ST_DONE);
  assign err = err_r;
  assign err_code = code_r;
  assign push_s.valid = (state_r == ext_reg_pkg::ST_PUSH);
  assign push_s.data = data_r;

  // A stalled host only holds the engine in PUSH, never drops a word
  two_entry_buffer #(.W(ext_reg_pkg::WORD_W)) u_buf (
    .clk(clk),
    .reset(reset),
    .in_s(push_s),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_direct_map;
    state_r == ext_reg_pkg::ST_CHECK && op_dec == ext_reg_pkg::OP_DREAD |=>
      cur_word_r == $past(dev_ofs) && cur_blk_r == $past(dmap_blk);
  endproperty
  a_direct_map: assert property (p_direct_map)
    else $error("direct number mapped to wrong block or word");

  property p_no_ext;
    state_r == ext_reg_pkg::ST_CHECK && cpu_kind == ext_reg_pkg::CPU_NO_EXT
      |=> done && err;
  endproperty
  a_no_ext: assert property (p_no_ext)
    else $error("access allowed without extension registers");

  property p_block_err;
    done && err_code == ext_reg_pkg::ERR_BLOCK |-> $past(block_detect);
  endproperty
  a_block_err: assert property (p_block_err)
    else $error("block error without detecting memory");

  // Without block detection a batch request may legally reach a hole
  property p_small_set;
    mem_req && cpu_kind == ext_reg_pkg::CPU_SMALL &&
      (block_detect || op_r == ext_reg_pkg::OP_DREAD) |->
      mem_block <= ext_reg_pkg::SMALL_LAST_BLK;
  endproperty
  a_small_set: assert property (p_small_set)
    else $error("small variant accessed a block above three");

  property p_large_set;
    mem_req && cpu_kind == ext_reg_pkg::CPU_LARGE &&
      op_r == ext_reg_pkg::OP_DREAD |->
      mem_block != ext_reg_pkg::LARGE_GAP_BLK &&
      mem_block <= ext_reg_pkg::LARGE_LAST_BLK;
  endproperty
  a_large_set: assert property (p_large_set)
    else $error("large variant direct access to missing block");

  property p_read_data;
    mem_req && mem_ack && !mem_we |=>
      push_s.valid && push_s.data == $past(mem_rdata);
  endproperty
  a_read_data: assert property (p_read_data)
    else $error("read word not forwarded");

  property p_cmd_code;
    mem_req |-> op_r != ext_reg_pkg::OP_BAD &&
      (cmd0_r == ext_reg_pkg::CHR_E || cmd0_r == ext_reg_pkg::CHR_N);
  endproperty
  a_cmd_code: assert property (p_cmd_code)
    else $error("memory access for unknown command");

  property p_reject;
    state_r == ext_reg_pkg::ST_CHECK && chk_err |=> !mem_req [*2];
  endproperty
  a_reject: assert property (p_reject)
    else $error("rejected request reached memory");

  c_bread: cover property (mem_req && mem_ack && op_r ==
                           ext_reg_pkg::OP_BREAD);
  c_write_done: cover property (done && !err && mem_we);
  c_block_err: cover property (done && err_code == ext_reg_pkg::ERR_BLOCK);
  c_stall: cover property (push_s.valid && !push_s.ready);
endmodule // ext_reg_cmd

// ---- dv/mem_model.sv ----
/*
  Behavioural model of the controller CPU memory port seen by the
  command engine. Assumes the engine holds its request until the ack.
*/
module mem_model (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Latency choice
  input wire logic slow,
  // Memory port
  input wire logic mem_req,
  input wire logic [ext_reg_pkg::BLK_W-1:0] mem_block,
  input wire logic [ext_reg_pkg::OFS_W-1:0] mem_word,
  output logic mem_ack,
  output logic [ext_reg_pkg::WORD_W-1:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] wait_r;
  // ==========================================================
  // Ack after zero or three waits; data only valid with the ack
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mem_ack <= 1'h0;
      wait_r <= 2'h0;
      mem_rdata <= 16'h0000;
    end else if (mem_req && !mem_ack && wait_r == (slow ? 2'h3 : 2'h0)) begin
      mem_ack <= 1'h1;
      wait_r <= 2'h0;
      mem_rdata <= {mem_block[3:0], mem_word[11:0]};
    end else begin
      mem_ack <= 1'h0;
      // Stale data flips so a late sample never matches by chance
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) begin
        wait_r <= wait_r + 2'h1;
      end
    end
  end
endmodule // mem_model

// ---- dv/tb_top.sv ----
/*
  Self-checking bench of the extension register command engine.
  Assumes the engine contract of one request at a time.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0;
  logic reset = 1'h1;
  ext_reg_pkg::cpu_kind_t cpu_kind = ext_reg_pkg::CPU_LARGE;
  logic [8:0] block_limit = 9'h000;
  logic block_detect = 1'h1;
  logic slow = 1'h0;
  logic req_valid = 1'h0;
  logic req_ready;
  logic [7:0] req_cmd0 = 8'h00;
  logic [7:0] req_cmd1 = 8'h00;
  logic [8:0] req_block = 9'h000;
  logic [12:0] req_word = 13'h0000;
  logic [17:0] req_dev = 18'h0_0000;
  logic [6:0] req_points = 7'h00;
  logic wr_valid = 1'h0;
  logic wr_ready;
  logic [15:0] wr_data = 16'h0000;
  logic rd_valid;
  logic rd_ready = 1'h0;
  logic [15:0] rd_data;
  logic done, err, mem_req, mem_we, mem_ack;
  logic [7:0] err_code;
  logic [8:0] mem_block;
  logic [12:0] mem_word;
  logic [15:0] mem_wdata, mem_rdata;
  int mismatches = 0;
  int comparisons = 0;
  logic [15:0] rdq[$];
  logic [38:0] mlog[$];
  logic [15:0] wdat[64];
  logic [7:0] code;
  logic e;

  ext_reg_cmd ext_reg_cmd_inst (.clk(clk), .reset(reset),
    .cpu_kind(cpu_kind), .block_limit(block_limit),
    .block_detect(block_detect), .req_valid(req_valid),
    .req_ready(req_ready), .req_cmd0(req_cmd0), .req_cmd1(req_cmd1),
    .req_block(req_block), .req_word(req_word), .req_dev(req_dev),
    .req_points(req_points), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_data(wr_data), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .rd_data(rd_data), .done(done), .err(err), .err_code(err_code),
    .mem_req(mem_req), .mem_we(mem_we), .mem_block(mem_block),
    .mem_word(mem_word), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));
  mem_model mem_model_inst (.clk(clk), .reset(reset), .slow(slow),
    .mem_req(mem_req), .mem_block(mem_block), .mem_word(mem_word),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  always #10 clk = ~clk;
  // Signals settle between edges, so the falling edge sees a transfer
  always @(negedge clk) begin
    if (mem_req && mem_ack) begin
      mlog.push_back({mem_we, mem_block, mem_word, mem_wdata});
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      mismatches++;
    end
  endtask

  // Runs one request; stall holds the read side off that many cycles
  task automatic xact(logic [7:0] c0, logic [7:0] c1, logic [8:0] blk,
      logic [12:0] wd, logic [17:0] dev, logic [6:0] pts, int nwr,
      int stall);
    int n;
    int wi;
    logic fin;
    rdq.delete();
    mlog.delete();
    wi = 0;
    n = 0;
    fin = 1'h0;
    @(negedge clk);
    req_cmd0 = c0;
    req_cmd1 = c1;
    req_block = blk;
    req_word = wd;
    req_dev = dev;
    req_points = pts;
    req_valid = 1'h1;
    while (!req_ready && n < 50) begin
      @(negedge clk);
      n++;
    end
    if (!req_ready) begin
      mismatches++;
      $display("CHECK FAILED req_ready expected 1 seen 0");
      tally_and_finish();
    end
    @(negedge clk);
    req_valid = 1'h0;
    n = 0;
    while (n < 3000 && !(fin && !rd_valid)) begin
      wr_valid = (wi < nwr);
      wr_data = wdat[wi[5:0]];
      rd_ready = (n >= stall);
      #1;
      if (wr_valid && wr_ready) wi++;
      if (rd_valid && rd_ready) rdq.push_back(rd_data);
      if (done) begin
        fin = 1'h1;
        code = err_code;
        e = err;
      end
      @(negedge clk);
      n++;
    end
    wr_valid = 1'h0;
    // A drain that never empties is a hang as much as a missing done
    if (!fin || rd_valid) begin
      mismatches++;
      $display("CHECK FAILED request end expected 1 seen 0");
      tally_and_finish();
    end
  endtask

  task automatic chk_acc(int i, logic [8:0] blk, logic [12:0] wd,
      logic we, logic [15:0] wv);
    chk("access", {we, blk, wd}, mlog[i][38:16]);
    if (we) chk("write data", wv, mlog[i][15:0]);
    else chk("read data", {blk[3:0], wd[11:0]}, rdq[i]);
  endtask

  task automatic chk_ok(int pts);
    chk("err_code", 8'h00, code);
    chk("err", 1'h0, e);
    chk("access count", pts, mlog.size());
  endtask

  // ==========================================================
  // Scenarios
  task automatic s_batch_read_stall();
    cpu_kind = ext_reg_pkg::CPU_LARGE;
    slow = 1'h1;
    xact(8'h45, 8'h52, 9'h00c, 13'h1ffc, 18'h0, 7'h04, 0, 20);
    chk_ok(4);
    chk("words delivered", 4, rdq.size());
    for (int i = 0; i < 4; i++) chk_acc(i, 9'h00c, 13'h1ffc + i, 0, 0);
    slow = 1'h0;
  endtask

  task automatic s_batch_write();
    wdat[0] = 16'h1234;
    wdat[1] = 16'h1a1b;
    wdat[2] = 16'h0506;
    xact(8'h45, 8'h57, 9'h005, 13'h1b62, 18'h0, 7'h03, 3, 0);
    chk_ok(3);
    for (int i = 0; i < 3; i++) chk_acc(i, 9'h005, 13'h1b62 + i, 1, wdat[i]);
  endtask

  task automatic s_direct_read();
    cpu_kind = ext_reg_pkg::CPU_LARGE;
    xact(8'h4e, 8'h52, 9'h0, 13'h0, 18'h0_ffff, 7'h02, 0, 0);
    chk_ok(2);
    chk_acc(0, 9'h008, 13'h1fff, 0, 0);
    chk_acc(1, 9'h00a, 13'h0000, 0, 0);
    xact(8'h4e, 8'h52, 9'h0, 13'h0, 18'h1_dfff, 7'h01, 0, 0);
    chk_ok(1);
    chk_acc(0, 9'h010, 13'h1fff, 0, 0);
    cpu_kind = ext_reg_pkg::CPU_SMALL;
    xact(8'h4e, 8'h52, 9'h0, 13'h0, 18'h0_5ffe, 7'h02, 0, 0);
    chk_ok(2);
    chk_acc(1, 9'h003, 13'h1fff, 0, 0);
  endtask

  task automatic s_max_points();
    cpu_kind = ext_reg_pkg::CPU_GENERAL;
    block_limit = 9'h005;
    xact(8'h45, 8'h52, 9'h005, 13'h1fc0, 18'h0, 7'h40, 0, 3);
    chk_ok(64);
    for (int i = 0; i < 64; i++) chk_acc(i, 9'h005, 13'h1fc0 + i, 0, 0);
  endtask

  task automatic try_err(ext_reg_pkg::cpu_kind_t k, logic [7:0] c0,
      logic [7:0] c1, logic [8:0] blk, logic [12:0] wd, logic [17:0] dev,
      logic [6:0] pts, logic [7:0] exp);
    cpu_kind = k;
    xact(c0, c1, blk, wd, dev, pts, 0, 0);
    chk("err_code", exp, code);
    chk("err", 1'h1, e);
    chk("access count", 0, mlog.size());
    chk("words delivered", 0, rdq.size());
  endtask

  task automatic s_errors();
    try_err(ext_reg_pkg::CPU_LARGE, 8'h45, 8'h52, 9'h1, 13'h0, 18'h0,
      7'h00, 8'h10);
    try_err(ext_reg_pkg::CPU_LARGE, 8'h45, 8'h52, 9'h1, 13'h0, 18'h0,
      7'h41, 8'h10);
    try_err(ext_reg_pkg::CPU_LARGE, 8'h45, 8'h57, 9'h1, 13'h1ffe, 18'h0,
      7'h03, 8'h10);
    try_err(ext_reg_pkg::CPU_SMALL, 8'h4e, 8'h52, 9'h0, 13'h0, 18'h0_5fff,
      7'h02, 8'h10);
    try_err(ext_reg_pkg::CPU_LARGE, 8'h4e, 8'h57, 9'h0, 13'h0, 18'h0,
      7'h01, 8'h11);
    try_err(ext_reg_pkg::CPU_LARGE, 8'h45, 8'h54, 9'h1, 13'h0, 18'h0,
      7'h01, 8'h11);
    try_err(ext_reg_pkg::CPU_NO_EXT, 8'h45, 8'h52, 9'h1, 13'h0, 18'h0,
      7'h01, 8'h12);
    try_err(ext_reg_pkg::CPU_LARGE, 8'h45, 8'h52, 9'h9, 13'h0, 18'h0,
      7'h01, 8'h06);
    try_err(ext_reg_pkg::CPU_SMALL, 8'h45, 8'h52, 9'h4, 13'h0, 18'h0,
      7'h01, 8'h06);
    block_limit = 9'h005;
    try_err(ext_reg_pkg::CPU_GENERAL, 8'h45, 8'h52, 9'h6, 13'h0, 18'h0,
      7'h01, 8'h06);
  endtask

  task automatic s_no_detect();
    cpu_kind = ext_reg_pkg::CPU_LARGE;
    block_detect = 1'h0;
    xact(8'h45, 8'h52, 9'h009, 13'h0010, 18'h0, 7'h01, 0, 0);
    chk_ok(1);
    chk_acc(0, 9'h009, 13'h0010, 0, 0);
    block_detect = 1'h1;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    reset = 1'h0;
    s_batch_read_stall();
    s_batch_write();
    s_direct_read();
    s_max_points();
    s_errors();
    s_no_detect();
    tally_and_finish();
  end
endmodule // tb_top
